// File: logic/pts_timebase.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// timebase routing and pwm channels behind an apb slave
module pts_timebase (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] tmr_count [3], // period timer counts
  input wire logic [2:0] tmr_match, // period timer reload pulses
  output logic [3:0] pwm_out, // pwm levels, one per channel
  output logic [7:0] ch_timer_idx // effective timer per channel
);

  logic [7:0] sel_r;
  logic [3:0] en_r;
  logic [7:0] duty_r [4];
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic access;
  logic wr_done;
  logic [2:0] duty_slot;
  logic duty_hit;

  // access phase and the edge at which a write completes
  always_comb begin
    access = psel && penable && !pready;
    wr_done = psel && penable && pready && pwrite;
  end

  // duty register address decode
  always_comb begin
    duty_hit = (paddr >= pts_pkg::ADDR_DUTY_BASE) && (paddr <= pts_pkg::ADDR_DUTY_LAST)
               && (paddr[1:0] == 2'h0);
    duty_slot = 3'((paddr - pts_pkg::ADDR_DUTY_BASE) >> 2);
  end

  // read mux and unmapped detection
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (duty_hit) begin
      rdata_nxt = {24'h00_0000, duty_r[duty_slot[1:0]]};
    end else begin
      case (paddr)
        pts_pkg::ADDR_SEL: begin
          rdata_nxt = {24'h00_0000, sel_r};
        end
        pts_pkg::ADDR_EN: begin
          rdata_nxt = {28'h000_0000, en_r};
        end
        pts_pkg::ADDR_STAT: begin
          rdata_nxt = {20'h0_0000, pwm_out, ch_timer_idx};
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  // one wait state, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= access;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
        pslverr <= err_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // timer selection register, all fields read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= pts_pkg::SEL_RESET;
    end else if (ce) begin
      if (wr_done && (paddr == pts_pkg::ADDR_SEL)) begin
        sel_r <= pwdata[7:0];
      end
    end
  end

  // pwm mode enables: bits 1:0 units, bits 3:2 pwm channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= pts_pkg::EN_RESET;
    end else if (ce) begin
      if (wr_done && (paddr == pts_pkg::ADDR_EN)) begin
        en_r <= pwdata[3:0];
      end
    end
  end

  // duty registers, one per channel
  generate
    for (genvar d = 0; d < pts_pkg::NUM_CH; d++) begin : g_duty
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_r[d] <= pts_pkg::DUTY_RESET;
        end else if (ce) begin
          if (wr_done && duty_hit && (duty_slot == 3'(d))) begin
            duty_r[d] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  // effective timer per channel, reserved code mapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_timer_idx <= pts_pkg::SEL_RESET;
    end else if (ce) begin
      ch_timer_idx[pts_pkg::FOURTH_PWM_SEL_LSB +: pts_pkg::SEL_W] <=
        pts_pkg::route_timer(sel_r[pts_pkg::FOURTH_PWM_SEL_LSB +: pts_pkg::SEL_W]);
      ch_timer_idx[pts_pkg::THIRD_PWM_SEL_LSB +: pts_pkg::SEL_W] <=
        pts_pkg::route_timer(sel_r[pts_pkg::THIRD_PWM_SEL_LSB +: pts_pkg::SEL_W]);
      ch_timer_idx[pts_pkg::SECOND_UNIT_SEL_LSB +: pts_pkg::SEL_W] <=
        pts_pkg::route_timer(sel_r[pts_pkg::SECOND_UNIT_SEL_LSB +: pts_pkg::SEL_W]);
      ch_timer_idx[pts_pkg::FIRST_UNIT_SEL_LSB +: pts_pkg::SEL_W] <=
        pts_pkg::route_timer(sel_r[pts_pkg::FIRST_UNIT_SEL_LSB +: pts_pkg::SEL_W]);
    end
  end

  // identical channel logic for both units and both pwm channels
  generate
    for (genvar c = 0; c < pts_pkg::NUM_CH; c++) begin : g_ch
      pts_pwm_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sel(sel_r[pts_pkg::SEL_W*c +: pts_pkg::SEL_W]),
        .en(en_r[c]),
        .duty(duty_r[c]),
        .tmr_count(tmr_count),
        .tmr_match(tmr_match),
        .pwm_out(pwm_out[c])
      );
    end
  endgenerate

  // checks on the routing and the bus
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fourth_pwm_route_a:
  assert property (ce |=> ch_timer_idx[7:6] == pts_pkg::route_timer($past(sel_r[7:6])))
    else $error("fourth pwm channel timer route wrong");

  third_pwm_route_a:
  assert property (ce && sel_r[5:4] != pts_pkg::TMR_RESERVED |=> ch_timer_idx[5:4] ==
                   $past(sel_r[5:4]))
    else $error("third pwm channel timer route wrong");

  second_unit_route_a:
  assert property (ce && sel_r[3:2] == pts_pkg::TMR_THIRD |=>
                   ch_timer_idx[3:2] == pts_pkg::TMR_THIRD)
    else $error("second unit not on third timer");

  first_unit_route_a:
  assert property (ce && sel_r[1:0] == pts_pkg::TMR_SECOND |=>
                   ch_timer_idx[1:0] == pts_pkg::TMR_SECOND)
    else $error("first unit not on second timer");

  sel_write_a:
  assert property (ce && wr_done && paddr == pts_pkg::ADDR_SEL |=> sel_r == $past(pwdata[7:0]))
    else $error("selection write not stored");

  reserved_fallback_a:
  assert property (ce && sel_r[1:0] == pts_pkg::TMR_RESERVED |=>
                   ch_timer_idx[1:0] == pts_pkg::TMR_FIRST)
    else $error("reserved code not routed to first timer");

  field_independent_a:
  assert property (ce && $past(ce) && $stable(sel_r[7:2]) |=> $stable(ch_timer_idx[7:2]))
    else $error("other channel route moved");

  pwm_disabled_low_a:
  assert property (ce && en_r == 4'h0 |=> pwm_out == 4'h0)
    else $error("pwm output high while disabled");

  apb_ready_once_a:
  assert property (ce && access |=> pready ##1 (!pready || !$past(ce)))
    else $error("apb ready timing wrong");

endmodule : pts_timebase

// File: logic/pts_pkg.sv
package pts_pkg;

  // channel and timer counts
  localparam int NUM_CH = 4;
  localparam int NUM_UNITS = 2;
  localparam int NUM_TMR = 3;
  localparam int SEL_W = 2;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // channel slots in the selection register
  localparam int CH_FIRST_UNIT = 0;
  localparam int CH_SECOND_UNIT = 1;
  localparam int CH_THIRD_PWM = 2;
  localparam int CH_FOURTH_PWM = 3;

  // field positions (lsb) in the selection register
  localparam int FIRST_UNIT_SEL_LSB = 0;
  localparam int SECOND_UNIT_SEL_LSB = 2;
  localparam int THIRD_PWM_SEL_LSB = 4;
  localparam int FOURTH_PWM_SEL_LSB = 6;

  // timer codes
  localparam logic [1:0] TMR_FIRST = 2'h0;
  localparam logic [1:0] TMR_SECOND = 2'h1;
  localparam logic [1:0] TMR_THIRD = 2'h2;
  localparam logic [1:0] TMR_RESERVED = 2'h3;

  // register byte addresses
  localparam logic [11:0] ADDR_SEL = 12'h000;
  localparam logic [11:0] ADDR_EN = 12'h004;
  localparam logic [11:0] ADDR_DUTY_BASE = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h018;
  localparam logic [11:0] ADDR_DUTY_LAST = 12'h014;

  // reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // reserved code falls back to the first timer
  function automatic logic [1:0] route_timer(input logic [1:0] code);
    route_timer = (code == TMR_RESERVED) ? TMR_FIRST : code;
  endfunction : route_timer

endpackage : pts_pkg

// File: logic/pts_pwm_chan.sv
`timescale 1ns/1ns
// one pwm channel, identical for every unit and channel
module pts_pwm_chan (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [1:0] sel, // timer select code
  input wire logic en, // pwm mode enable
  input wire logic [7:0] duty, // programmed duty
  input wire logic [7:0] tmr_count [3], // timer counts
  input wire logic [2:0] tmr_match, // timer period match pulses
  output logic pwm_out // pwm level
);

  logic [1:0] idx;
  logic [7:0] cnt;
  logic reload;
  logic [7:0] duty_act_r;

  // pick the timer that drives this channel
  always_comb begin
    idx = pts_pkg::route_timer(sel);
    cnt = tmr_count[idx];
    reload = tmr_match[idx];
  end

  // duty takes effect at the start of a period to avoid glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_act_r <= pts_pkg::DUTY_RESET;
    end else if (ce) begin
      if (reload || !en) begin
        duty_act_r <= duty;
      end
    end
  end

  // output high while the count is below the duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else if (ce) begin
      pwm_out <= en && (cnt < duty_act_r);
    end
  end

endmodule : pts_pwm_chan

// File: dv/pts_timer_model.sv
`timescale 1ns/1ns
// three free-running auto-reload period timers feeding the channels
module pts_timer_model #(
  parameter int P0 = 9,
  parameter int P1 = 20,
  parameter int P2 = 37
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  output logic [7:0] tmr_count [3], // timer counts
  output logic [2:0] tmr_match // one-cycle pulse at reload
);
  localparam int PER [3] = '{P0, P1, P2};

  // count up to the period, then reload to zero with a match pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_count <= '{8'h00, 8'h00, 8'h00};
      tmr_match <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        tmr_match[i] <= (tmr_count[i] == 8'(PER[i]));
        tmr_count[i] <= (tmr_count[i] == 8'(PER[i])) ? 8'h00 : tmr_count[i] + 8'h01;
      end
    end
  end
endmodule : pts_timer_model

// File: dv/pts_timebase_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module pts_timebase_tb;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] tmr_count [3], prev [3], ch_timer_idx;
  logic [2:0] tmr_match;
  logic [3:0] pwm_out, en_m = 4'h0;
  int err_count = 0, n_tests = 0, seed = 32'h5405CC53, sel_m = 0, v, duty_m [4];
  bit chk_pwm = 0;

  always #4 pclk = ~pclk;

  pts_timebase pts_timebase_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_count(tmr_count), .tmr_match(tmr_match),
    .pwm_out(pwm_out), .ch_timer_idx(ch_timer_idx));
  pts_timer_model pts_timer_model_i (.pclk(pclk), .presetn(presetn), .tmr_count(tmr_count),
    .tmr_match(tmr_match));

  // effective timer of one channel, reserved code falls back to the first
  function automatic int tsel(int s, int c);
    tsel = (s >> (2 * c)) & 3;
    if (tsel == 3) tsel = 0;
  endfunction : tsel

  function automatic logic [7:0] route(int s);
    for (int c = 0; c < 4; c++) route[2*c +: 2] = 2'(tsel(s, c));
  endfunction : route

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input int a, input int d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= 12'(a); pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // pwm level against the selected timer count of the cycle before
  always @(negedge pclk) begin
    if (chk_pwm) for (int c = 0; c < 4; c++)
      `CHK("pwm_out", en_m[c] && prev[tsel(sel_m, c)] < duty_m[c], pwm_out[c])
    prev = tmr_count;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pts_pkg::ADDR_SEL, 0);
    `CHK("sel", 32'h0, q)
    `CHK("idx", 8'h00, ch_timer_idx)
    $display("test reset done");
    // every code in every field, other fields random
    for (int f = 0; f < 4; f++) for (int c = 0; c < 4; c++) begin
      v = ($random(seed) & 32'hFF & ~(3 << (2 * f))) | (c << (2 * f));
      apb(1, pts_pkg::ADDR_SEL, v);
      sel_m = v;
      apb(0, pts_pkg::ADDR_SEL, 0);
      `CHK("sel", v, q)
      `CHK("slverr", 1'b0, e)
      repeat (2) @(posedge pclk);
      `CHK("idx", route(v), ch_timer_idx)
      apb(0, pts_pkg::ADDR_STAT, 0);
      `CHK("stat", route(v), q[7:0])
      `CHK("stat_hi", 24'h00_0000, q[31:8])
    end
    $display("test routing done");
    apb(0, 12'h01C, 0);
    `CHK("slverr", 1'b1, e)
    `CHK("rdata", 32'h0, q)
    $display("test unmapped done");
    // pwm from each channel's own timer and duty
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        duty_m[c] = ($random(seed) & 32'hFF) % 41;
        apb(1, pts_pkg::ADDR_DUTY_BASE + 4 * c, duty_m[c]);
      end
      en_m = k ? 4'hF : 4'h5;
      apb(1, pts_pkg::ADDR_EN, en_m);
      apb(0, pts_pkg::ADDR_EN, 0);
      `CHK("en", en_m, q)
      v = $random(seed) & 32'hFF;
      apb(1, pts_pkg::ADDR_SEL, v);
      sel_m = v;
      repeat (300) @(posedge pclk);
      chk_pwm = 1;
      repeat (200) @(posedge pclk);
      chk_pwm = 0;
    end
    $display("test pwm done");
    // clock enable low freezes outputs while the timers keep running
    @(posedge pclk);
    ce <= 1'b0;
    @(negedge pclk);
    q = {20'h0_0000, pwm_out, ch_timer_idx};
    repeat (20) begin
      @(negedge pclk);
      `CHK("frozen", q, {20'h0_0000, pwm_out, ch_timer_idx})
    end
    @(posedge pclk);
    ce <= 1'b1;
    $display("test clock enable done");
    // reset in mid-run clears the selection
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pts_pkg::ADDR_SEL, 0);
    `CHK("sel", 32'h0, q)
    `CHK("idx", 8'h00, ch_timer_idx)
    `CHK("pwm", 4'h0, pwm_out)
    $display("test second reset done");
    finish_test();
  end
endmodule : pts_timebase_tb
